// *** core/nand_ecc_pkg.sv ***
package nand_ecc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned UNIT_BYTES = 512;
  localparam int unsigned IDX_W = 9;
  localparam int unsigned COL_W = 6;
  localparam int unsigned ROW_W = 2 * IDX_W;
  localparam int unsigned CODE_W = COL_W + ROW_W;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_CODE = 8'h0C;
  localparam logic [7:0] ADDR_STORED = 8'h10;
  localparam logic [7:0] ADDR_SYNDROME = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;
  localparam logic [7:0] ADDR_COUNT = 8'h1C;

  // Control bits, write only, self clearing
  localparam int unsigned CTRL_RESTART_BIT = 0;
  localparam int unsigned CTRL_CHECK_BIT = 1;

  // Status and mask bits
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_UNIT_DONE_BIT = 0;
  localparam int unsigned EVT_CORRECTABLE_BIT = 1;
  localparam int unsigned EVT_UNCORRECTABLE_BIT = 2;

  // Column field order inside a code, high to low
  localparam int unsigned COL_TRUE_HI = 5;
  localparam int unsigned COL_COMPL_HI = 4;
  localparam int unsigned COL_TRUE_MID = 3;
  localparam int unsigned COL_COMPL_MID = 2;
  localparam int unsigned COL_TRUE_LO = 1;
  localparam int unsigned COL_COMPL_LO = 0;

  // Result register layout
  localparam int unsigned RES_BIT_LSB = 0;
  localparam int unsigned RES_BYTE_LSB = 4;
  localparam int unsigned RES_CORRECTABLE_BIT = 16;
  localparam int unsigned RES_UNCORRECTABLE_BIT = 17;
  localparam int unsigned RES_NO_ERROR_BIT = 18;

  localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
  localparam logic [CODE_W-1:0] CODE_RESET = 24'h000000;

endpackage

// *** core/byte_parity.sv ***
// Per-byte parity terms feeding the column and row accumulators
module byte_parity (
  input wire logic [7:0] data_byte,
  output logic [5:0] column_bits,
  output logic all_bits
);

  always_comb begin
    column_bits[nand_ecc_pkg::COL_TRUE_HI] = ^{data_byte[7], data_byte[6], data_byte[5], data_byte[4]};
    column_bits[nand_ecc_pkg::COL_TRUE_MID] = ^{data_byte[7], data_byte[6], data_byte[3], data_byte[2]};
    column_bits[nand_ecc_pkg::COL_TRUE_LO] = ^{data_byte[7], data_byte[5], data_byte[3], data_byte[1]};
    column_bits[nand_ecc_pkg::COL_COMPL_HI] = ^{data_byte[3], data_byte[2], data_byte[1], data_byte[0]};
    column_bits[nand_ecc_pkg::COL_COMPL_MID] = ^{data_byte[5], data_byte[4], data_byte[1], data_byte[0]};
    column_bits[nand_ecc_pkg::COL_COMPL_LO] = ^{data_byte[6], data_byte[4], data_byte[2], data_byte[0]};
    all_bits = ^data_byte;
  end

endmodule // byte_parity

// *** core/nand_page_xor_ecc.sv ***
module nand_page_xor_ecc #(
  parameter int unsigned UNIT_BYTES = nand_ecc_pkg::UNIT_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic [nand_ecc_pkg::ADDR_W-1:0] addr,
  input wire logic [nand_ecc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [nand_ecc_pkg::DATA_W-1:0] rdata,
  output logic irq
);

  localparam int unsigned IDX_W = nand_ecc_pkg::IDX_W;
  localparam int unsigned COL_W = nand_ecc_pkg::COL_W;
  localparam int unsigned ROW_W = nand_ecc_pkg::ROW_W;
  localparam int unsigned CODE_W = nand_ecc_pkg::CODE_W;
  localparam int unsigned EVT_W = nand_ecc_pkg::EVT_W;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(UNIT_BYTES - 1);
  localparam int unsigned PAIRS = COL_W / 2 + IDX_W;

  logic [COL_W-1:0] col_acc;
  logic [ROW_W-1:0] row_acc;
  logic [IDX_W-1:0] count;
  logic [CODE_W-1:0] code;
  logic [CODE_W-1:0] stored;
  logic [CODE_W-1:0] syndrome;
  logic [2:0] err_bit;
  logic [IDX_W-1:0] err_byte;
  logic correctable;
  logic uncorrectable;
  logic no_error;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;

  logic [COL_W-1:0] next_col_acc;
  logic [ROW_W-1:0] next_row_acc;
  logic [IDX_W-1:0] next_count;
  logic [CODE_W-1:0] next_code;
  logic [CODE_W-1:0] next_stored;
  logic [CODE_W-1:0] next_syndrome;
  logic [2:0] next_err_bit;
  logic [IDX_W-1:0] next_err_byte;
  logic next_correctable;
  logic next_uncorrectable;
  logic next_no_error;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] next_mask;
  logic [nand_ecc_pkg::DATA_W-1:0] next_rdata;
  logic next_irq;

  logic [COL_W-1:0] byte_cols;
  logic byte_par;
  logic [ROW_W-1:0] row_terms;
  logic [ROW_W/2+COL_W/2-1:0] pair_diff;
  logic [CODE_W-1:0] syn_now;
  logic [PAIRS-1:0] pair_one;
  logic [PAIRS-1:0] pair_zero;
  logic [EVT_W-1:0] events;
  logic restart;
  logic check;
  logic unit_end;

  byte_parity u_byte_parity (
    .data_byte(data_byte),
    .column_bits(byte_cols),
    .all_bits(byte_par)
  );

  // Row pair k: true collects bytes whose index bit k is one, complement those with zero
  genvar k;
  generate
    for (k = 0; k < IDX_W; k++) begin : g_row
      assign row_terms[2*k+1] = byte_par & count[k];
      assign row_terms[2*k] = byte_par & ~count[k];
    end
  endgenerate

  assign restart = wr && (addr == nand_ecc_pkg::ADDR_CTRL) && wdata[nand_ecc_pkg::CTRL_RESTART_BIT];
  assign check = wr && (addr == nand_ecc_pkg::ADDR_CTRL) && wdata[nand_ecc_pkg::CTRL_CHECK_BIT];
  assign unit_end = data_valid && (count == LAST_IDX);

  // Accumulation over one unit
  always_comb begin
    logic [COL_W-1:0] base_col;
    logic [ROW_W-1:0] base_row;
    logic [IDX_W-1:0] base_count;
    base_col = restart ? '0 : col_acc;
    base_row = restart ? '0 : row_acc;
    base_count = restart ? '0 : count;
    next_col_acc = base_col;
    next_row_acc = base_row;
    next_count = base_count;
    next_code = code;
    if (data_valid) begin
      if (restart) begin
        // Byte arriving with a restart is byte 0 of the new unit
        next_col_acc = byte_cols;
        next_row_acc = {IDX_W{2'b01}} & {ROW_W{byte_par}};
        next_count = IDX_W'(1);
      end else if (unit_end) begin
        next_code = {base_row ^ row_terms, base_col ^ byte_cols};
        next_col_acc = '0;
        next_row_acc = '0;
        next_count = '0;
      end else begin
        next_col_acc = base_col ^ byte_cols;
        next_row_acc = base_row ^ row_terms;
        next_count = base_count + IDX_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      col_acc <= '0;
      row_acc <= '0;
      count <= '0;
      code <= nand_ecc_pkg::CODE_RESET;
    end else if (ce) begin
      col_acc <= next_col_acc;
      row_acc <= next_row_acc;
      count <= next_count;
      code <= next_code;
    end
  end

  // Compare and decode
  assign syn_now = stored ^ code;

  // Pair p: true half at bit 2p+1, complement half at bit 2p
  genvar p;
  generate
    for (p = 0; p < PAIRS; p++) begin : g_pair
      assign pair_one[p] = syn_now[2*p+1] & ~syn_now[2*p];
      assign pair_zero[p] = ~syn_now[2*p+1] & syn_now[2*p];
      assign pair_diff[p] = pair_one[p] | pair_zero[p];
    end
  endgenerate

  always_comb begin
    next_stored = stored;
    if (wr && (addr == nand_ecc_pkg::ADDR_STORED)) begin
      next_stored = wdata[CODE_W-1:0];
    end
    next_syndrome = syndrome;
    next_err_bit = err_bit;
    next_err_byte = err_byte;
    next_correctable = correctable;
    next_uncorrectable = uncorrectable;
    next_no_error = no_error;
    if (check) begin
      next_syndrome = syn_now;
      // Column pairs sit lowest, highest pair first, so they read as the bit position
      next_err_bit = pair_one[COL_W/2-1:0];
      next_err_byte = pair_one[PAIRS-1:COL_W/2];
      next_no_error = (syn_now == '0);
      next_correctable = &pair_diff;
      // A flipped stored bit or a double error leaves some pair equal
      next_uncorrectable = (syn_now != '0) && !(&pair_diff);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stored <= nand_ecc_pkg::CODE_RESET;
      syndrome <= '0;
      err_bit <= '0;
      err_byte <= '0;
      correctable <= 1'b0;
      uncorrectable <= 1'b0;
      no_error <= 1'b0;
    end else if (ce) begin
      stored <= next_stored;
      syndrome <= next_syndrome;
      err_bit <= next_err_bit;
      err_byte <= next_err_byte;
      correctable <= next_correctable;
      uncorrectable <= next_uncorrectable;
      no_error <= next_no_error;
    end
  end

  // Register slave and interrupt
  always_comb begin
    events = '0;
    events[nand_ecc_pkg::EVT_UNIT_DONE_BIT] = unit_end && !restart;
    events[nand_ecc_pkg::EVT_CORRECTABLE_BIT] = check && next_correctable;
    events[nand_ecc_pkg::EVT_UNCORRECTABLE_BIT] = check && next_uncorrectable;
    next_mask = mask;
    if (wr && (addr == nand_ecc_pkg::ADDR_MASK)) begin
      next_mask = wdata[EVT_W-1:0];
    end
    // A new event in the clearing cycle survives the read
    next_status = status | events;
    if (rd && (addr == nand_ecc_pkg::ADDR_STATUS)) begin
      next_status = events;
    end
    next_rdata = '0;
    if (rd) begin
      if (addr == nand_ecc_pkg::ADDR_STATUS) begin
        next_rdata[EVT_W-1:0] = status;
      end else if (addr == nand_ecc_pkg::ADDR_MASK) begin
        next_rdata[EVT_W-1:0] = mask;
      end else if (addr == nand_ecc_pkg::ADDR_CODE) begin
        next_rdata[CODE_W-1:0] = code;
      end else if (addr == nand_ecc_pkg::ADDR_STORED) begin
        next_rdata[CODE_W-1:0] = stored;
      end else if (addr == nand_ecc_pkg::ADDR_SYNDROME) begin
        next_rdata[CODE_W-1:0] = syndrome;
      end else if (addr == nand_ecc_pkg::ADDR_RESULT) begin
        next_rdata[nand_ecc_pkg::RES_BIT_LSB +: 3] = err_bit;
        next_rdata[nand_ecc_pkg::RES_BYTE_LSB +: IDX_W] = err_byte;
        next_rdata[nand_ecc_pkg::RES_CORRECTABLE_BIT] = correctable;
        next_rdata[nand_ecc_pkg::RES_UNCORRECTABLE_BIT] = uncorrectable;
        next_rdata[nand_ecc_pkg::RES_NO_ERROR_BIT] = no_error;
      end else if (addr == nand_ecc_pkg::ADDR_COUNT) begin
        next_rdata[IDX_W-1:0] = count;
      end
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status <= '0;
      mask <= nand_ecc_pkg::MASK_RESET;
      rdata <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      status <= next_status;
      mask <= next_mask;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

endmodule // nand_page_xor_ecc

// *** verif/nand_ecc_chk.sv ***
module nand_ecc_chk #(
  parameter int unsigned UNIT_BYTES = 512
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (ce && !rd |=> rdata == 32'h0)
    else $error("rdata not zero after idle cycle");
  a_unmapped_zero: assert property (ce && rd && addr > 8'h1C |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_zero: assert property (ce && rd && addr == 8'h00 |=> rdata == 32'h0)
    else $error("control read not zero");
  a_freeze_out: assert property (!ce |=> rdata == $past(rdata) && irq == $past(irq))
    else $error("outputs moved while disabled");
  a_mask_back: assert property (ce && wr && addr == 8'h08 ##1 ce && rd && addr == 8'h08
    |=> rdata == ($past(wdata, 2) & 32'h7)) else $error("mask readback wrong");
  a_stored_back: assert property (ce && wr && addr == 8'h10 ##1 ce && rd && addr == 8'h10
    |=> rdata == ($past(wdata, 2) & 32'hFFFFFF)) else $error("stored readback wrong");
  a_mask_off_irq: assert property (ce && wr && addr == 8'h08 && wdata[2:0] == 3'h0 |=> !irq)
    else $error("irq high with all masked");
  a_verdict_onehot: assert property (ce && wr && addr == 8'h00 && wdata[1] ##1 ce && rd && addr == 8'h18
    |=> $onehot(rdata[18:16])) else $error("check verdict not one-hot");
  cover property (ce && wr && addr == 8'h00 && wdata[1]);
  cover property (irq);
  cover property (data_valid && data_byte != 8'h00);
  cover property (ce && wr && addr == 8'h00 && wdata[0] && data_valid);
endmodule // nand_ecc_chk

bind nand_page_xor_ecc nand_ecc_chk #(.UNIT_BYTES(UNIT_BYTES)) u_chk (.clk(clk), .rst(rst), .ce(ce),
  .data_valid(data_valid), .data_byte(data_byte), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq));

// *** verif/nand_flash_model.sv ***
module nand_flash_model #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic slow,
  input wire logic [7:0] page [N],
  output logic data_valid,
  output logic [7:0] data_byte,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int idx;
  logic gap;
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      data_valid <= 1'b0;
      data_byte <= 8'h00;
      idx <= 0;
      gap <= 1'b0;
    end else if (busy && !(slow && gap)) begin
      data_valid <= 1'b1;
      data_byte <= page[idx];
      idx <= idx + 1;
      busy <= (idx != N - 1);
      gap <= 1'b1;
    end else begin
      // Idle bus drops data_valid and inverts data_byte again on every idle cycle
      data_valid <= 1'b0;
      data_byte <= ~data_byte;
      gap <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        idx <= 0;
      end
    end
  end
endmodule // nand_flash_model

// *** verif/tb_nand_page_xor_ecc.sv ***
module tb_nand_page_xor_ecc;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 4;
  logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, start = 0, slow = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic data_valid, busy, irq;
  logic [7:0] data_byte;
  logic [7:0] pg [N] = '{default: 8'h00};
  logic [23:0] c_old, c_new;
  int err_count = 0, n_tests = 0;
  always #50 clk = ~clk;
  nand_page_xor_ecc #(.UNIT_BYTES(N)) u_dut (.clk(clk), .rst(rst), .ce(ce), .data_valid(data_valid),
    .data_byte(data_byte), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  nand_flash_model #(.N(N)) u_flash (.clk(clk), .rst(rst), .start(start), .slow(slow), .page(pg),
    .data_valid(data_valid), .data_byte(data_byte), .busy(busy));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  // Reference code built bit by bit, independent of the design
  task automatic stream(logic [7:0] b [N], logic s, output logic [23:0] c);
    c = 24'h0;
    wr <= 1'b0;
    rd <= 1'b0;
    slow <= s;
    start <= 1'b1;
    foreach (b[i]) begin
      pg[i] <= b[i];
      c[5] ^= ^b[i][7:4];
      c[4] ^= ^b[i][3:0];
      c[3] ^= ^{b[i][7:6], b[i][3:2]};
      c[2] ^= ^{b[i][5:4], b[i][1:0]};
      c[1] ^= ^{b[i][7], b[i][5], b[i][3], b[i][1]};
      c[0] ^= ^{b[i][6], b[i][4], b[i][2], b[i][0]};
      for (int k = 0; k < 9; k++) c[6 + 2 * k + ((i >> k) & 1)] ^= ^b[i];
    end
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 20 && (i < 2 || busy); i++) @(posedge clk);
    @(posedge clk);
  endtask
  task automatic t_reset();
    logic [7:0] al [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
    foreach (al[i]) begin
      rd_reg(al[i]);
      chk("reset read", 32'h0, v);
    end
    chk("reset irq", 32'h0, {31'h0, irq});
  endtask
  task automatic t_unit();
    logic [7:0] b [N] = '{8'h00, 8'h02, 8'h00, 8'h00};
    wr_reg(8'h08, 32'h1);
    rd_reg(8'h08);
    chk("mask", 32'h1, v);
    stream(b, 1'b1, c_old);
    rd_reg(8'h0C);
    chk("code", {8'h0, c_old}, v);
    chk("irq set", 32'h1, {31'h0, irq});
    addr <= 8'h0C;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("frozen rdata", {8'h0, c_old}, rdata);
    @(posedge clk);
    ce <= 1'b1;
    rd_reg(8'h04);
    chk("status", 32'h1, v);
    chk("irq clear", 32'h0, {31'h0, irq});
    rd_reg(8'h1C);
    chk("count", 32'h0, v);
  endtask
  // Restart lands beside byte 1, which becomes byte 0 of a new partial unit
  task automatic t_restart();
    logic [7:0] b [N] = '{8'h11, 8'h22, 8'h33, 8'h44};
    wr <= 1'b0;
    rd <= 1'b0;
    slow <= 1'b1;
    start <= 1'b1;
    foreach (b[i]) pg[i] <= b[i];
    @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
    wr_reg(8'h00, 32'h1);
    wr <= 1'b0;
    repeat (5) @(posedge clk);
    rd_reg(8'h1C);
    chk("count after restart", 32'h3, v);
    rd_reg(8'h04);
    chk("no unit done", 32'h0, v);
    wr_reg(8'h00, 32'h1);
    rd_reg(8'h1C);
    chk("count cleared", 32'h0, v);
  endtask
  task automatic t_check();
    logic [7:0] b [N] = '{8'h00, 8'h22, 8'h00, 8'h00};
    logic [23:0] s;
    logic [8:0] byt;
    wr_reg(8'h10, {8'h0, c_old});
    rd_reg(8'h10);
    chk("stored", {8'h0, c_old}, v);
    stream(b, 1'b0, c_new);
    s = c_old ^ c_new;
    for (int k = 0; k < 9; k++) byt[k] = s[7 + 2 * k];
    wr_reg(8'h00, 32'h2);
    rd_reg(8'h18);
    chk("result", {15'h0, 1'b1, 3'h0, byt, 1'b0, s[5], s[3], s[1]}, v);
    rd_reg(8'h14);
    chk("syndrome", {8'h0, s}, v);
    rd_reg(8'h04);
    chk("check status", 32'h3, v);
    wr_reg(8'h08, 32'h0);
    for (int j = 0; j < 2; j++) begin
      wr_reg(8'h10, {8'h0, c_new ^ 24'(j)});
      wr_reg(8'h00, 32'h2);
      rd_reg(8'h18);
      chk("verdict", j ? 32'h20000 : 32'h40000, v & 32'h70000);
    end
    chk("masked irq", 32'h0, {31'h0, irq});
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1000000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_unit();
    t_restart();
    t_check();
    complete_run();
  end
endmodule // tb_nand_page_xor_ecc
